// ### rtl/cfxm_defines.svh
// Purpose: shared constants of the clock failure and slow crystal monitor
// Assumes: reference clock of 100 MHz stands in for the main RC oscillator
// Notes: offsets are byte addresses on APB, one 32-bit word per register
`ifndef CFXM_DEFINES_SVH
`define CFXM_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CFXM_REF_HZ 100000000
`define CFXM_SLOW_RC_HZ 32000
`define CFXM_SLOW_DIV (`CFXM_REF_HZ / `CFXM_SLOW_RC_HZ)
`define CFXM_XTAL_HZ 32768
`define CFXM_TOL_PCT 10
`define CFXM_NOM_CYC (`CFXM_REF_HZ / `CFXM_XTAL_HZ)
`define CFXM_MIN_CYC (`CFXM_NOM_CYC * (100 - `CFXM_TOL_PCT) / 100)
`define CFXM_MAX_CYC (`CFXM_NOM_CYC * (100 + `CFXM_TOL_PCT) / 100)
`define CFXM_BAD_RUN 4
`define CFXM_STARTUP_MULT 8

// ****************************************************************
// register offsets
// ****************************************************************
`define CFXM_OFF_MOR 12'h000
`define CFXM_OFF_MCKR 12'h004
`define CFXM_OFF_SR 12'h008
`define CFXM_OFF_IER 12'h00c
`define CFXM_OFF_IDR 12'h010
`define CFXM_OFF_IMR 12'h014
`define CFXM_OFF_FOCR 12'h018

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CFXM_MOR_XTEN 0
`define CFXM_MOR_RCEN 3
`define CFXM_MOR_ST_LO 8
`define CFXM_MOR_ST_HI 15
`define CFXM_MOR_SEL 24
`define CFXM_MOR_FME 26
`define CFXM_MOR_WMASK 32'h0500_ff09
`define CFXM_MOR_RST 32'h0000_0008
`define CFXM_MCKR_RST 2'h1
`define CFXM_SR_XTS 0
`define CFXM_SR_RCS 17
`define CFXM_SR_CFD 18
`define CFXM_SR_FOS 20
`define CFXM_SR_XTERR 21
`define CFXM_SR_IRQ_MASK 32'h0027_0001
`define CFXM_FOCR_CLR 0

`endif

// ### rtl/cfxm_pkg.sv
// Purpose: types of the clock failure and slow crystal monitor
// Assumes: nothing beyond the defines header
// Notes: constants live in the defines header, types here
package cfxm_pkg;

    // master clock source selection
    typedef enum logic [1:0] {
        CFXM_SRC_SLOW,
        CFXM_SRC_MAIN,
        CFXM_SRC_PLL,
        CFXM_SRC_RSVD
    } cfxm_src_e;

    // main crystal start-up sequence
    typedef enum logic [1:0] {
        CFXM_OSC_OFF,
        CFXM_OSC_WAIT,
        CFXM_OSC_READY
    } cfxm_osc_e;

    typedef struct packed {
        logic [31:0] mor;
        logic [1:0] mckr;
        logic [31:0] imr;
        logic [31:0] rdata;
        cfxm_osc_e osc;
        logic [10:0] st_cnt;
        logic xtal_prev;
        logic act_seen;
        logic cfd;
        logic forced;
        logic fault;
        logic xterr;
        cfxm_src_e mck_sel;
        logic rc_sel;
        logic rc_en;
        logic xt_en;
    } cfxm_state_s;

    typedef struct packed {
        logic [11:0] cnt;
        logic tick;
    } cfxm_tick_s;

    typedef struct packed {
        logic prev;
        logic started;
        logic [12:0] cnt;
        logic [2:0] bad;
        logic invalid;
    } cfxm_meas_s;

endpackage

// ### rtl/cfxm_tick.sv
// Purpose: slow RC clock enable, one pulse per slow clock period
// Assumes: ref_clk at the rate in the defines header
// Notes: the pulse replaces a real slow clock domain
`timescale 1ns/10ps
`default_nettype none
`include "cfxm_defines.svh"

module cfxm_tick
    import cfxm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic tick
);
    cfxm_tick_s st_r;
    cfxm_tick_s st_nxt;

    // free-running divider
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = (st_r.cnt == 12'(`CFXM_SLOW_DIV - 1));
        st_nxt.cnt = st_nxt.tick ? 12'h000 : st_r.cnt + 12'h001;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule // cfxm_tick
`default_nettype wire

// ### rtl/cfxm_top.sv
// Purpose: main crystal failure detection, switchover and slow crystal monitor
// Assumes: APB slave, zero wait states; slow RC clock is an enable pulse
// Notes: clock inputs are sampled levels; ref_clk stands in for the main RC
`timescale 1ns/10ps
`default_nettype none
`include "cfxm_defines.svh"

module cfxm_top
    import cfxm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_xtal_in,
    input wire logic slow_xtal_in,
    input wire logic fast_rc_ready,
    output logic fault_out,
    output logic [1:0] master_clk_sel,
    output logic main_clk_sel_rc,
    output logic fast_rc_en,
    output logic main_xtal_en,
    output logic pm_irq
);
    // ****************************************************************
    // state and helpers
    // ****************************************************************
    localparam cfxm_state_s RST = '{
        mor: `CFXM_MOR_RST, mckr: `CFXM_MCKR_RST, imr: 32'h0000_0000,
        rdata: 32'h0000_0000, osc: CFXM_OSC_OFF, st_cnt: 11'h000,
        xtal_prev: 1'b0, act_seen: 1'b0, cfd: 1'b0, forced: 1'b0,
        fault: 1'b0, xterr: 1'b0, mck_sel: CFXM_SRC_MAIN, rc_sel: 1'b1,
        rc_en: 1'b1, xt_en: 1'b0};

    cfxm_state_s st_r;
    cfxm_state_s st_nxt;
    logic tick;
    logic meas_invalid;
    logic [31:0] sr;
    logic wr_en;
    logic rd_setup;
    logic focr_clr;
    logic mon_on;
    logic cfd_new;
    logic [10:0] st_target;

    // address decode for the error answer; the read mux decodes on its own
    function automatic logic cfxm_mapped(input logic [11:0] a);
        return (a == `CFXM_OFF_MOR) || (a == `CFXM_OFF_MCKR) || (a == `CFXM_OFF_SR) ||
               (a == `CFXM_OFF_IER) || (a == `CFXM_OFF_IDR) || (a == `CFXM_OFF_IMR) ||
               (a == `CFXM_OFF_FOCR);
    endfunction

    // ****************************************************************
    // sub-blocks
    // ****************************************************************
    cfxm_tick u_tick (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    cfxm_xtal_meas u_meas (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(st_r.mor[`CFXM_MOR_FME]),
        .slow_xtal_in(slow_xtal_in),
        .invalid(meas_invalid)
    );

    // status word, built from live state
    always_comb begin
        sr = 32'h0000_0000;
        sr[`CFXM_SR_XTS] = (st_r.osc == CFXM_OSC_READY);
        sr[`CFXM_SR_RCS] = fast_rc_ready;
        sr[`CFXM_SR_CFD] = st_r.cfd;
        sr[`CFXM_SR_FOS] = st_r.fault;
        sr[`CFXM_SR_XTERR] = st_r.xterr;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        wr_en = psel & penable & pwrite;
        rd_setup = psel & ~penable & ~pwrite;
        focr_clr = wr_en && (paddr == `CFXM_OFF_FOCR) && pwdata[`CFXM_FOCR_CLR];
        st_target = 11'(st_r.mor[`CFXM_MOR_ST_HI:`CFXM_MOR_ST_LO] * `CFXM_STARTUP_MULT);

        // register writes; a write takes effect in the access phase
        if (wr_en) begin
            unique case (paddr)
                `CFXM_OFF_MOR: st_nxt.mor = pwdata & `CFXM_MOR_WMASK;
                `CFXM_OFF_MCKR: st_nxt.mckr = pwdata[1:0];
                `CFXM_OFF_IER: st_nxt.imr = st_r.imr | (pwdata & `CFXM_SR_IRQ_MASK);
                `CFXM_OFF_IDR: st_nxt.imr = st_r.imr & ~pwdata;
                default: ;
            endcase
        end

        // crystal start-up: count slow ticks, eight per count unit
        unique case (st_r.osc)
            CFXM_OSC_OFF: begin
                st_nxt.st_cnt = 11'h000;
                if (st_r.mor[`CFXM_MOR_XTEN]) begin
                    st_nxt.osc = CFXM_OSC_WAIT;
                end
            end
            CFXM_OSC_WAIT: begin
                if (!st_r.mor[`CFXM_MOR_XTEN]) begin
                    st_nxt.osc = CFXM_OSC_OFF;
                end else if (st_r.st_cnt >= st_target) begin
                    st_nxt.osc = CFXM_OSC_READY;
                end else if (tick) begin
                    st_nxt.st_cnt = st_r.st_cnt + 11'h001;
                end
            end
            CFXM_OSC_READY: begin
                if (!st_r.mor[`CFXM_MOR_XTEN]) begin
                    st_nxt.osc = CFXM_OSC_OFF;
                end
            end
            // the fourth code is never entered; fall back to off
            default: begin
                st_nxt.osc = CFXM_OSC_OFF;
            end
        endcase

        // crystal activity seen between two slow ticks
        st_nxt.xtal_prev = main_xtal_in;
        if (tick) begin
            st_nxt.act_seen = (main_xtal_in != st_r.xtal_prev);
        end else if (main_xtal_in != st_r.xtal_prev) begin
            st_nxt.act_seen = 1'b1;
        end

        // a whole slow period with no crystal edge is a failure
        mon_on = st_r.mor[`CFXM_MOR_XTEN] & st_r.mor[`CFXM_MOR_SEL] &
                 (st_r.osc == CFXM_OSC_READY) & ~st_r.cfd;
        if (tick && mon_on && !st_r.act_seen) begin
            st_nxt.cfd = 1'b1;
        end
        cfd_new = st_nxt.cfd & ~st_r.cfd;

        // switch at once from main, one slow period later from pll
        if (cfd_new && (st_r.mckr != 2'(CFXM_SRC_PLL))) begin
            st_nxt.forced = 1'b1;
        end else if (st_r.cfd && !st_r.forced && tick) begin
            st_nxt.forced = 1'b1;
        end

        // reselecting the RC by software ends the forced state
        // a failure latched in the same cycle wins; it ends one cycle later
        if (!st_nxt.mor[`CFXM_MOR_SEL] && !cfd_new) begin
            st_nxt.cfd = 1'b0;
            st_nxt.forced = 1'b0;
        end

        // fault output: a new failure wins over a clear in the same cycle
        st_nxt.fault = cfd_new | (st_r.fault & ~focr_clr);

        // slow crystal error: sticky while enabled, cleared while disabled
        st_nxt.xterr = st_r.mor[`CFXM_MOR_FME] ? (st_r.xterr | meas_invalid)
                                               : 1'b0;

        // registered clock selects
        st_nxt.mck_sel = st_nxt.forced ? CFXM_SRC_MAIN : cfxm_src_e'(st_nxt.mckr);
        st_nxt.rc_sel = ~st_nxt.mor[`CFXM_MOR_SEL] | st_nxt.forced;
        st_nxt.rc_en = st_nxt.mor[`CFXM_MOR_RCEN] | st_nxt.forced;
        st_nxt.xt_en = st_nxt.mor[`CFXM_MOR_XTEN];

        // read data is captured in the setup phase
        if (rd_setup) begin
            unique case (paddr)
                `CFXM_OFF_MOR: st_nxt.rdata = st_r.mor;
                `CFXM_OFF_MCKR: st_nxt.rdata = {30'h0000_0000, st_r.mckr};
                `CFXM_OFF_SR: st_nxt.rdata = sr;
                `CFXM_OFF_IMR: st_nxt.rdata = st_r.imr;
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // zero wait state slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~cfxm_mapped(paddr);
    assign prdata = st_r.rdata;
    assign fault_out = st_r.fault;
    assign master_clk_sel = st_r.mck_sel;
    assign main_clk_sel_rc = st_r.rc_sel;
    assign fast_rc_en = st_r.rc_en;
    assign main_xtal_en = st_r.xt_en;
    // enabled status bits drive the power manager line
    assign pm_irq = |(sr & st_r.imr);

    // ****************************************************************
    // check helpers
    // ****************************************************************
    // cycles from a latched failure to the forced switch; a whole slow
    // period is too long a delay range, so a counter carries it
    logic [12:0] late_cnt_r;
    logic [12:0] late_cnt_nxt;

    always_comb begin
        late_cnt_nxt = 13'h0000;
        if (st_r.cfd && !st_r.forced) begin
            late_cnt_nxt = late_cnt_r + 13'h0001;
        end
    end

    // a deselect clears the failure latch, and with it the count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            late_cnt_r <= 13'h0000;
        end else begin
            late_cnt_r <= late_cnt_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    fault_hold_a: assert property (fault_out && !focr_clr |=> fault_out)
        else $error("fault output dropped without clear");
    fault_raise_a: assert property ($rose(st_r.cfd) |-> fault_out)
        else $error("failure without fault output");
    mck_force_a: assert property (st_r.forced |-> master_clk_sel == 2'(CFXM_SRC_MAIN))
        else $error("master clock not forced to main");
    rc_force_a: assert property (st_r.forced |-> main_clk_sel_rc && fast_rc_en)
        else $error("main clock not forced to fast RC");
    switch_main_a: assert property ($rose(st_r.cfd) && st_r.mckr != 2'h2 |-> st_r.forced)
        else $error("late switchover from main");
    switch_pll_a: assert property (late_cnt_r <= 13'(`CFXM_SLOW_DIV))
        else $error("late switchover from pll");
    fos_level_a: assert property (sr[`CFXM_SR_FOS] == fault_out)
        else $error("fault status differs from output");
    err_sticky_a: assert property (st_r.xterr && st_r.mor[`CFXM_MOR_FME] |=> st_r.xterr)
        else $error("error flag cleared while monitoring");
    err_set_a: assert property (st_r.mor[`CFXM_MOR_FME] && meas_invalid |=> st_r.xterr)
        else $error("error flag missed");
    stable_time_a: assert property ($rose(sr[`CFXM_SR_XTS]) |-> $past(st_r.st_cnt) >=
                                    11'(8 * $past(st_r.mor[15:8])))
        else $error("crystal stable too early");
    irq_stable_a: assert property (sr[`CFXM_SR_XTS] && st_r.imr[`CFXM_SR_XTS] |-> pm_irq)
        else $error("stable interrupt missing");
    irq_xterr_a: assert property (st_r.xterr && st_r.imr[`CFXM_SR_XTERR] |-> pm_irq)
        else $error("error interrupt missing");
    focr_zero_a: assert property (rd_setup && paddr == `CFXM_OFF_FOCR |=> prdata == 0)
        else $error("clear register reads nonzero");
    // clear, set-wins, monitor off and crystal off
    fault_clear_a: assert property (fault_out && focr_clr && !cfd_new |=> !fault_out)
        else $error("fault output survived its clear");
    fault_new_a: assert property (cfd_new |=> fault_out)
        else $error("new failure lost to a clear");
    err_clear_a: assert property (!st_r.mor[`CFXM_MOR_FME] |=> !st_r.xterr)
        else $error("error flag held while monitor off");
    mon_off_a: assert property (!st_r.mor[`CFXM_MOR_FME] |=> !meas_invalid)
        else $error("monitor ran while disabled");
    xts_drop_a: assert property (!st_r.mor[`CFXM_MOR_XTEN] |=> !sr[`CFXM_SR_XTS])
        else $error("stable bit kept with crystal off");

endmodule // cfxm_top
`default_nettype wire

// ### rtl/cfxm_xtal_meas.sv
// Purpose: period measurement of the slow crystal against ref_clk
// Assumes: slow_xtal_in synchronous to ref_clk
// Notes: a stopped crystal counts as one bad period per overrun
`timescale 1ns/10ps
`default_nettype none
`include "cfxm_defines.svh"

module cfxm_xtal_meas
    import cfxm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic slow_xtal_in,
    output logic invalid
);
    cfxm_meas_s st_r;
    cfxm_meas_s st_nxt;
    logic rise;
    logic over;
    logic bad_now;

    // one measurement per rising edge; the first edge only opens a window
    always_comb begin
        st_nxt = st_r;
        rise = slow_xtal_in & ~st_r.prev;
        over = (st_r.cnt > 13'(`CFXM_MAX_CYC));
        bad_now = over | (rise & (st_r.cnt < 13'(`CFXM_MIN_CYC)));
        st_nxt.prev = slow_xtal_in;
        st_nxt.cnt = st_r.cnt + 13'h0001;
        if (rise || over) begin
            st_nxt.cnt = 13'h0000;
            st_nxt.started = 1'b1;
            if (st_r.started) begin
                if (bad_now) begin
                    st_nxt.bad = (st_r.bad == 3'(`CFXM_BAD_RUN)) ? st_r.bad
                                                                 : st_r.bad + 3'h1;
                end else begin
                    st_nxt.bad = 3'h0;
                end
            end
        end
        st_nxt.invalid = (st_nxt.bad == 3'(`CFXM_BAD_RUN));
        if (!enable) begin
            st_nxt = '0;
            st_nxt.prev = slow_xtal_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign invalid = st_r.invalid;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    bad_run_a: assert property (st_r.bad != 3'h0 && st_r.bad < 3'h4 |-> !invalid)
        else $error("flagged before four bad periods");

endmodule // cfxm_xtal_meas
`default_nettype wire

// ### test/cfxm_osc_model.sv
// Purpose: far side model: main crystal, slow crystal, fast RC oscillator
// Assumes: levels change just after ref_clk rising edges
// Notes: a failed crystal freezes its level, as a dead resonator would
`timescale 1ns/10ps
`default_nettype none

module cfxm_osc_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic main_xtal_en,
    input wire logic fast_rc_en,
    input wire logic main_run,
    input wire logic [15:0] slow_period,
    output logic main_xtal_in,
    output logic slow_xtal_in,
    output logic fast_rc_ready
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [2:0] div;
        logic xt;
        logic [15:0] cnt;
        logic [3:0] rc_dly;
    } cfxm_osc_s;
    cfxm_osc_s st_r;
    cfxm_osc_s st_nxt;

    // crystal toggles only while powered and healthy
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = st_r.div + 3'h1;
        if (main_xtal_en && main_run && st_r.div == 3'h0) begin
            st_nxt.xt = ~st_r.xt;
        end
        st_nxt.cnt = (st_r.cnt >= slow_period - 16'h1) ? 16'h0 : st_r.cnt + 16'h1;
        st_nxt.rc_dly = {st_r.rc_dly[2:0], fast_rc_en};  // settles in four cycles
        if (sys_rst) begin
            st_nxt = '0;
        end
    end

    // one register for the whole state
    always_ff @(posedge ref_clk) begin
        st_r <= st_nxt;
    end

    assign main_xtal_in = st_r.xt;
    assign slow_xtal_in = (st_r.cnt < {1'b0, slow_period[15:1]});
    assign fast_rc_ready = &st_r.rc_dly;
endmodule // cfxm_osc_model

`default_nettype wire

// ### test/test_clock_failure_and_xtal_monitor.sv
// Purpose: self-checking bench of the clock failure and slow crystal monitor
// Assumes: APB slave answers when pready is high; 100 MHz ref_clk
// Notes: startup count 1 keeps the run short (eight slow ticks)
`timescale 1ns/10ps
`default_nettype none
`include "cfxm_defines.svh"

module test_clock_failure_and_xtal_monitor;
    // ****************************************************************
    // signals and expected state
    // ****************************************************************
    localparam int TICK = `CFXM_SLOW_DIV;
    localparam logic [31:0] XTS = 32'h1 << `CFXM_SR_XTS;
    localparam logic [31:0] RCS = 32'h1 << `CFXM_SR_RCS;
    localparam logic [31:0] CFD = 32'h1 << `CFXM_SR_CFD;
    localparam logic [31:0] FAULT_OUTPUT_STATUS = 32'h1 << `CFXM_SR_FOS;
    localparam logic [31:0] XERR = 32'h1 << `CFXM_SR_XTERR;
    localparam logic [31:0] FME = 32'h0400_0000;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, r, exp_mor, exp_imr;
    logic main_xtal_in, slow_xtal_in, fast_rc_ready, fault_out, main_clk_sel_rc;
    logic fast_rc_en, main_xtal_en, pm_irq, main_run, e;
    logic [1:0] master_clk_sel;
    logic [15:0] slow_period;
    logic [31:0] seed = 32'h16;
    int miscompares = 0;
    int compares = 0;
    int n, p;

    cfxm_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_xtal_in(main_xtal_in),
        .slow_xtal_in(slow_xtal_in), .fast_rc_ready(fast_rc_ready), .fault_out(fault_out),
        .master_clk_sel(master_clk_sel), .main_clk_sel_rc(main_clk_sel_rc),
        .fast_rc_en(fast_rc_en), .main_xtal_en(main_xtal_en), .pm_irq(pm_irq));
    cfxm_osc_model i_osc (.ref_clk(ref_clk), .sys_rst(sys_rst), .main_xtal_en(main_xtal_en),
        .fast_rc_en(fast_rc_en), .main_run(main_run), .slow_period(slow_period),
        .main_xtal_in(main_xtal_in), .slow_xtal_in(slow_xtal_in),
        .fast_rc_ready(fast_rc_ready));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        if (k >= 50) begin
            check(32'h0, 32'h1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // bounded wait: which 0 watches pm_irq, 1 watches fault_out
    task automatic wait_hi(input logic which, input int lim, output int cnt);
        cnt = 0;
        while ((which ? fault_out : pm_irq) !== 1'b1 && cnt < lim) begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************************************
    // clock, watchdog, tests
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // tests need about 92000 cycles at most
    initial begin
        idle(98000);
        miscompares++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        {sys_rst, main_run} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        slow_period = 16'd3052;
        exp_imr = 32'h0;
        idle(8);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(32'({fault_out, master_clk_sel, main_clk_sel_rc, fast_rc_en, main_xtal_en,
            pm_irq}), 32'h1c);
        rd_chk(`CFXM_OFF_MOR, 32'h0000_0008);
        rd_chk(`CFXM_OFF_MCKR, 32'h1);
        rd_chk(`CFXM_OFF_FOCR, 32'h0);
        rd_chk(12'h01c, 32'h0);
        check({31'h0, e}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            wr(`CFXM_OFF_IER, r);
            exp_imr = exp_imr | (r & `CFXM_SR_IRQ_MASK);
            r = xs();
            wr(`CFXM_OFF_IDR, r);
            exp_imr = exp_imr & ~(r & `CFXM_SR_IRQ_MASK);
            rd_chk(`CFXM_OFF_IMR, exp_imr);
            check({31'h0, pm_irq}, {31'h0, exp_imr[17]});
        end
        wr(`CFXM_OFF_IDR, 32'hffff_ffff);
        $display("test reset_and_mask done");
        // crystal start-up, count of one unit
        wr(`CFXM_OFF_MCKR, 32'h0);
        exp_mor = 32'h0100_0109;
        wr(`CFXM_OFF_MOR, exp_mor);
        wr(`CFXM_OFF_IER, XTS);
        wait_hi(1'b0, 8 * TICK + 20, n);
        check({31'h0, n > 7 * TICK - 20 && n <= 8 * TICK + 10}, 32'h1);
        rd_chk(`CFXM_OFF_SR, XTS | RCS);
        check(32'({master_clk_sel, main_clk_sel_rc, main_xtal_en}), 32'h1);
        wr(`CFXM_OFF_IDR, XTS);
        $display("test startup done");
        // slow crystal monitor
        rd_chk(`CFXM_OFF_SR, XTS | RCS);
        exp_mor = exp_mor | FME;
        wr(`CFXM_OFF_MOR, exp_mor);
        idle(10000);
        rd_chk(`CFXM_OFF_SR, XTS | RCS);
        exp_mor = exp_mor & ~FME;
        wr(`CFXM_OFF_MOR, exp_mor);
        p = 1500 + int'(xs() % 1000);
        slow_period <= 16'(p);
        idle(5 * p);
        rd_chk(`CFXM_OFF_SR, XTS | RCS);
        wr(`CFXM_OFF_IER, XERR);
        exp_mor = exp_mor | FME;
        wr(`CFXM_OFF_MOR, exp_mor);
        idle(3 * p - 20);
        #1;
        check({31'h0, pm_irq}, 32'h0);
        wait_hi(1'b0, 2 * p + 40, n);
        check({31'h0, pm_irq}, 32'h1);
        rd_chk(`CFXM_OFF_SR, XTS | RCS | XERR);
        slow_period <= 16'd3052;
        idle(2 * 3052);
        rd_chk(`CFXM_OFF_SR, XTS | RCS | XERR);
        exp_mor = exp_mor & ~FME;
        wr(`CFXM_OFF_MOR, exp_mor);
        rd_chk(`CFXM_OFF_SR, XTS | RCS);
        check({31'h0, pm_irq}, 32'h0);
        wr(`CFXM_OFF_IDR, XERR);
        $display("test slow_monitor done");
        // main crystal failure with fast RC switched off
        exp_mor = exp_mor & ~32'h8;
        wr(`CFXM_OFF_MOR, exp_mor);
        idle(2);
        #1;
        check({31'h0, fast_rc_en}, 32'h0);
        main_run <= 1'b0;
        wait_hi(1'b1, 2 * TICK + 20, n);
        check({31'h0, n <= 2 * TICK + 3}, 32'h1);
        check(32'({master_clk_sel, main_clk_sel_rc, fast_rc_en}), 32'h7);
        idle(TICK);
        rd_chk(`CFXM_OFF_SR, XTS | RCS | CFD | FAULT_OUTPUT_STATUS);
        wr(`CFXM_OFF_FOCR, 32'h0);
        rd_chk(`CFXM_OFF_FOCR, 32'h0);
        rd_chk(`CFXM_OFF_SR, XTS | RCS | CFD | FAULT_OUTPUT_STATUS);
        wr(`CFXM_OFF_FOCR, 32'h1);
        #1;
        check({31'h0, fault_out}, 32'h0);
        rd_chk(`CFXM_OFF_SR, XTS | RCS | CFD);
        $display("test failure done");
        // same failure while the pll drives the master clock
        main_run <= 1'b1;
        exp_mor = exp_mor & ~32'h0100_0000;
        wr(`CFXM_OFF_MOR, exp_mor);
        wr(`CFXM_OFF_MCKR, 32'h2);
        idle(TICK);
        rd_chk(`CFXM_OFF_SR, XTS);
        exp_mor = exp_mor | 32'h0100_0000;
        wr(`CFXM_OFF_MOR, exp_mor);
        idle(TICK);
        main_run <= 1'b0;
        wait_hi(1'b1, 2 * TICK + 20, n);
        check(32'({n <= 2 * TICK + 3, master_clk_sel}), 32'h6);
        idle(TICK + 1);
        #1;
        check(32'({master_clk_sel, main_clk_sel_rc, fast_rc_en}), 32'h7);
        $display("test pll_failure done");
        stop_test();
    end
endmodule // test_clock_failure_and_xtal_monitor

`default_nettype wire
